// *** hdl/strap_host_pkg.sv ***
// Function
// - Demote-select high: riser codec is primary and riser owns the link.
// - Demote-select low: primary codec sits on the motherboard.
// - Nothing on the motherboard drives SDATA_IN2 while reset is low.
// - Controller tolerates missing or non-sequential codec addresses.
// - Codecs keep data-in and bit clock tri-stated during link reset.
// - Motherboard codecs disable themselves while demote-select is high.
package strap_host_pkg;
   localparam int CLK_MHZ = 100;
   // Cold reset low time and post-release settle are free choices
   localparam int RESET_LOW_NS = 1000;
   localparam int SETUP_NS = 100;
   localparam int HOLD_NS = 10;
   localparam int SETTLE_NS = 1000;
   // Least times round up to whole cycles
   localparam int RESET_LOW_CYC = (RESET_LOW_NS * CLK_MHZ + 999) / 1000;
   localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
   localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W = 16;
   localparam int NUM_ADDR = 4;
   localparam logic [1:0] PRIMARY_ADDR = 2'h0;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RESET = 3'b001,
      ST_HOLD = 3'b010,
      ST_SETTLE = 3'b011,
      ST_RUN = 3'b100
   } host_state_t;
endpackage

// *** hdl/pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;

   // Two flops; only the second stage is visible outside
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= '0;
         sync_out <= '0;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule
`default_nettype wire

// *** hdl/codec_demote_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module codec_demote_host #(
   parameter bit THREE_CODEC = 1'b1,
   parameter int RESET_LOW = strap_host_pkg::RESET_LOW_CYC,
   parameter int SETTLE = strap_host_pkg::SETTLE_CYC
) (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic RESET_REQ,
   input wire logic CODEC_DEMOTE_SELECT_N,
   input wire logic SDATA_IN2,
   input wire logic [3:0] CODEC_READY,
   output logic AC97_RESET_N,
   output logic SDATA_IN2_PULLDOWN,
   output logic MB_CODEC_ENABLE,
   output logic PRIMARY_ON_RISER,
   output logic SDATA_IN2_CAPTURED,
   output logic [3:0] CODEC_PRESENT,
   output logic PRIMARY_PRESENT,
   output logic LINK_READY,
   output logic BUSY
);
   // Link reset must outlast the riser's setup window before the rising edge
   if (RESET_LOW < strap_host_pkg::SETUP_CYC + 1) begin
      $error("RESET_LOW shorter than the strap setup window");
   end
   // Every wait runs on one counter, so each last count must fit in it
   if (RESET_LOW >= (1 << strap_host_pkg::CNT_W)) begin
      $error("RESET_LOW does not fit the wait counter");
   end
   // The hold window keeps SDATA_IN2 quiet after release; it cannot be empty
   if (strap_host_pkg::HOLD_CYC < 1) begin
      $error("HOLD_CYC must be at least one cycle");
   end
   // Settling shorter than the hold would read straps before they stand
   if (SETTLE < strap_host_pkg::HOLD_CYC) begin
      $error("SETTLE shorter than the hold window");
   end
   if (SETTLE >= (1 << strap_host_pkg::CNT_W)) begin
      $error("SETTLE does not fit the wait counter");
   end

   // Last count of each wait; the counter starts from zero
   localparam logic [strap_host_pkg::CNT_W-1:0] LOW_LAST =
      strap_host_pkg::CNT_W'(RESET_LOW - 1);
   localparam logic [strap_host_pkg::CNT_W-1:0] HOLD_LAST =
      strap_host_pkg::CNT_W'(strap_host_pkg::HOLD_CYC - 1);
   localparam logic [strap_host_pkg::CNT_W-1:0] SETTLE_LAST =
      strap_host_pkg::CNT_W'(SETTLE - 1);

   // Synchronised copies of the pins
   logic demote_s;
   logic sdata2_s;
   logic [3:0] ready_s;

   // Demote-select, SDATA_IN2 and the ready pins cross two flops before any decision looks at them; RESET_REQ is used unsynchronised
   pin_sync #(
      .WIDTH(6)
   ) u_sync (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .async_in({CODEC_DEMOTE_SELECT_N, SDATA_IN2, CODEC_READY}),
      .sync_out({demote_s, sdata2_s, ready_s})
   );

   // Sequencer state and the status flops that feed the ports
   strap_host_pkg::host_state_t state, next_state;
   logic [strap_host_pkg::CNT_W-1:0] cnt, next_cnt;
   logic reset_n_q, next_reset_n_q;
   logic mb_en, next_mb_en;
   logic riser, next_riser;
   logic captured, next_captured;
   logic [3:0] present, next_present;
   logic prim, next_prim;
   logic ready, next_ready;

   // Board codec may run only while demote-select is low
   function automatic logic board_enable(input logic demote_level);
      return !demote_level;
   endfunction

   // Primary address bit, read in the last settle cycle and in run
   function automatic logic primary_seen(input logic [3:0] ready_mask);
      return ready_mask[strap_host_pkg::PRIMARY_ADDR];
   endfunction

   // Sequencer: hold reset, release, let straps settle, then read them
   always_comb begin
      next_state = state;
      next_cnt = cnt + 1'b1;
      next_reset_n_q = reset_n_q;
      next_mb_en = mb_en;
      next_riser = riser;
      next_captured = captured;
      next_present = present;
      next_prim = prim;
      next_ready = ready;
      unique case (state)
         strap_host_pkg::ST_IDLE: begin
            // Cold reset runs once after power-up without a request
            next_state = strap_host_pkg::ST_RESET;
            next_cnt = '0;
            next_reset_n_q = 1'b0;
            next_ready = 1'b0;
            next_mb_en = 1'b0;
         end
         strap_host_pkg::ST_RESET: begin
            // SDATA_IN2 undriven
            // Low time covers the riser's setup window before the edge
            if (cnt == LOW_LAST) begin
               next_state = strap_host_pkg::ST_HOLD;
               next_cnt = '0;
               next_reset_n_q = 1'b1;
            end
         end
         strap_host_pkg::ST_HOLD: begin
            // Level sampled one edge before the release edge, after sync delay
            if (cnt == '0) begin
               next_captured = sdata2_s;
            end
            // Still no drive on SDATA_IN2 through the hold window
            if (cnt == HOLD_LAST) begin
               next_state = strap_host_pkg::ST_SETTLE;
               next_cnt = '0;
            end
         end
         strap_host_pkg::ST_SETTLE: begin
            // Straps have stood long enough; take all status except captured at once
            if (cnt == SETTLE_LAST) begin
               next_state = strap_host_pkg::ST_RUN;
               next_riser = demote_s;
               next_mb_en = board_enable(demote_s);
               next_present = ready_s;
               next_prim = primary_seen(ready_s);
               next_ready = 1'b1;
            end
         end
         strap_host_pkg::ST_RUN: begin
            // Counter rests while the link runs
            next_cnt = cnt;
            // Demote-select may move only with a new reset; track it anyway
            next_riser = demote_s;
            next_mb_en = board_enable(demote_s);
            next_present = ready_s;
            next_prim = primary_seen(ready_s);
            // Requests count only here; elsewhere they are dropped unseen
            if (RESET_REQ) begin
               next_state = strap_host_pkg::ST_IDLE;
            end
         end
         default: begin
            // Unused codes fall back to a fresh cold reset
            next_state = strap_host_pkg::ST_IDLE;
         end
      endcase
   end

   // Plain register stage; every decision sits in the comb block above
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state <= strap_host_pkg::ST_IDLE;
         cnt <= '0;
         reset_n_q <= 1'b0;
         mb_en <= 1'b0;
         riser <= 1'b0;
         captured <= 1'b0;
         present <= 4'h0;
         prim <= 1'b0;
         ready <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         reset_n_q <= next_reset_n_q;
         mb_en <= next_mb_en;
         riser <= next_riser;
         captured <= next_captured;
         present <= next_present;
         prim <= next_prim;
         ready <= next_ready;
      end
   end

   // Busy and pull-down flops kept apart from the sequencer group
   logic busy_q, next_busy_q;
   logic pd_q;

   // Busy from the flop so the port stays register-driven
   always_comb begin
      next_busy_q = (next_state != strap_host_pkg::ST_RUN);
   end

   // Pull-down present only when the controller serves three codecs
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         busy_q <= 1'b1;
         pd_q <= 1'b0;
      end else begin
         busy_q <= next_busy_q;
         pd_q <= THREE_CODEC;
      end
   end

   // Ports come straight from flops so pins never see decode glitches
   assign AC97_RESET_N = reset_n_q;
   assign SDATA_IN2_PULLDOWN = pd_q;
   assign MB_CODEC_ENABLE = mb_en;
   assign PRIMARY_ON_RISER = riser;
   assign SDATA_IN2_CAPTURED = captured;
   assign CODEC_PRESENT = present;
   assign PRIMARY_PRESENT = prim;
   assign LINK_READY = ready;
   assign BUSY = busy_q;
endmodule
`default_nettype wire

// *** bench/codec_demote_host_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module codec_demote_host_assertions #(
   parameter bit THREE_CODEC = 1'b1
) (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic CODEC_DEMOTE_SELECT_N,
   input wire logic [3:0] CODEC_READY,
   input wire logic AC97_RESET_N,
   input wire logic SDATA_IN2_PULLDOWN,
   input wire logic MB_CODEC_ENABLE,
   input wire logic PRIMARY_ON_RISER,
   input wire logic [3:0] CODEC_PRESENT,
   input wire logic PRIMARY_PRESENT,
   input wire logic LINK_READY
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   // Pins reach the outputs three edges late: two sync flops and one output flop
   AST_RISER_PRIMARY: assert property (LINK_READY && $past(CODEC_DEMOTE_SELECT_N, 3) &&
      $past(CODEC_DEMOTE_SELECT_N, 4) |-> PRIMARY_ON_RISER && !MB_CODEC_ENABLE)
      else $error("riser primary not shown");
   AST_MB_PRIMARY: assert property (LINK_READY && !$past(CODEC_DEMOTE_SELECT_N, 3) &&
      !$past(CODEC_DEMOTE_SELECT_N, 4) |-> !PRIMARY_ON_RISER && MB_CODEC_ENABLE)
      else $error("board primary not shown");
   AST_PRESENT_MAP: assert property (LINK_READY && $past(LINK_READY) &&
      $past(CODEC_READY, 3) == $past(CODEC_READY, 4) |-> CODEC_PRESENT == $past(CODEC_READY, 3))
      else $error("codec map wrong");
   AST_PRIMARY_BIT: assert property (LINK_READY |-> PRIMARY_PRESENT == CODEC_PRESENT[0])
      else $error("primary bit wrong");
   AST_QUIET_IN_RESET: assert property (!AC97_RESET_N |-> !LINK_READY && !MB_CODEC_ENABLE)
      else $error("link claimed in reset");
   // First edge after system reset still shows the pull-down flop's reset value
   AST_PULLDOWN: assert property (!AC97_RESET_N && $past(RST_N) |->
      SDATA_IN2_PULLDOWN == THREE_CODEC)
      else $error("pull-down missing in reset");
   // Sensing window must not collapse to a glitch
   AST_RESET_WIDTH: assert property ($fell(AC97_RESET_N) |-> !AC97_RESET_N [*4])
      else $error("link reset too short");
endmodule
`default_nettype wire

// *** bench/riser_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module riser_model (
   input wire logic clk,
   input wire logic ac97_reset_n,
   input wire logic board_pd,
   output logic sdata_in2,
   output logic demote_n,
   output logic [3:0] codec_ready
);
   logic held;
   logic traffic;
   // latch follows in reset, holds after
   always_latch begin
      if (!ac97_reset_n) begin
         held <= sdata_in2;
      end
   end
   // Normal traffic toggles so a leaky latch would show
   always_ff @(posedge clk) begin
      traffic <= ac97_reset_n ? ~traffic : 1'b0;
   end
   // resistors alone set the line in reset
   assign sdata_in2 = !ac97_reset_n ? !board_pd : traffic;
   // weak pull-up loses to the board pull-down
   assign demote_n = held;
   // addresses from the demote level; none while link reset is low
   assign codec_ready = !ac97_reset_n ? 4'h0 : (demote_n ? 4'h3 : 4'h7);
endmodule
`default_nettype wire

// *** bench/codec_demote_strap_latch_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin errors++; \
   $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module codec_demote_strap_latch_tb_top;
   logic SYS_CLK = 1'b0;
   logic RST_N = 1'b0;
   logic RESET_REQ = 1'b0;
   logic pd_fit = 1'b1;
   wire logic demote_n, sd2, rst_n_link, pd, pd_eff, mb_en, on_riser, captured, link_ready;
   wire logic [3:0] ready, present;
   wire logic prim_present, busy;
   int errors = 0;
   int checked = 0;
   int cycles = 0;
   assign pd_eff = pd & pd_fit;
   codec_demote_host #(.RESET_LOW(12), .SETTLE(2)) u_dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
      .RESET_REQ(RESET_REQ), .CODEC_DEMOTE_SELECT_N(demote_n), .SDATA_IN2(sd2),
      .CODEC_READY(ready), .AC97_RESET_N(rst_n_link), .SDATA_IN2_PULLDOWN(pd),
      .MB_CODEC_ENABLE(mb_en), .PRIMARY_ON_RISER(on_riser), .SDATA_IN2_CAPTURED(captured),
      .CODEC_PRESENT(present), .PRIMARY_PRESENT(prim_present), .LINK_READY(link_ready),
      .BUSY(busy));
   riser_model u_riser (.clk(SYS_CLK), .ac97_reset_n(rst_n_link), .board_pd(pd_eff),
      .sdata_in2(sd2), .demote_n(demote_n), .codec_ready(ready));
   always #5 SYS_CLK = ~SYS_CLK;
   // Whole run needs about 120 cycles
   always @(posedge SYS_CLK) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         test_done();
      end
   end
   task automatic test_done();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic wait_ready();
      int n;
      n = 0;
      while (link_ready !== 1'b1 && n < 200) begin
         @(negedge SYS_CLK);
         n++;
      end
      `CHK("link ready", 1'b1, link_ready)
      `CHK("busy", 1'b0, busy)
      repeat (6) @(negedge SYS_CLK);
   endtask
   task automatic relink(input logic fit);
      pd_fit = fit;
      RESET_REQ = 1'b1;
      @(negedge SYS_CLK);
      RESET_REQ = 1'b0;
      repeat (3) @(negedge SYS_CLK);
      `CHK("link reset", 1'b0, rst_n_link)
      `CHK("busy in reset", 1'b1, busy)
      wait_ready();
   endtask
   task automatic test_weak();
      wait_ready();
      `CHK("mb enable", 1'b1, mb_en)
      `CHK("on riser", 1'b0, on_riser)
      `CHK("captured", 1'b0, captured)
      `CHK("present", 4'h7, present)
      `CHK("primary present", 1'b1, prim_present)
      $display("test_weak done");
   endtask
   task automatic test_strong();
      relink(1'b0);
      `CHK("on riser", 1'b1, on_riser)
      `CHK("mb enable", 1'b0, mb_en)
      `CHK("captured", 1'b1, captured)
      `CHK("present", 4'h3, present)
      `CHK("primary present", 1'b1, prim_present)
      repeat (20) @(negedge SYS_CLK);
      `CHK("still riser", 1'b1, on_riser)
      $display("test_strong done");
   endtask
   task automatic test_demote_again();
      relink(1'b1);
      `CHK("on riser", 1'b0, on_riser)
      `CHK("mb enable", 1'b1, mb_en)
      `CHK("present", 4'h7, present)
      $display("test_demote_again done");
   endtask
   // Mid-run system reset: the latch must follow the line, not keep the glitch
   task automatic test_sys_reset();
      RST_N = 1'b0;
      repeat (2) @(negedge SYS_CLK);
      `CHK("reset busy", 1'b1, busy)
      `CHK("reset link", 1'b0, rst_n_link)
      `CHK("reset mb enable", 1'b0, mb_en)
      RST_N = 1'b1;
      @(negedge SYS_CLK);
      `CHK("cold link reset", 1'b0, rst_n_link)
      wait_ready();
      `CHK("captured", 1'b0, captured)
      `CHK("mb enable", 1'b1, mb_en)
      `CHK("on riser", 1'b0, on_riser)
      $display("test_sys_reset done");
   endtask
   initial begin
      repeat (8) @(negedge SYS_CLK);
      RST_N = 1'b1;
      test_weak();
      test_strong();
      test_demote_again();
      test_sys_reset();
      test_done();
   end
endmodule
bind codec_demote_host codec_demote_host_assertions #(.THREE_CODEC(THREE_CODEC)) u_chk (
   .SYS_CLK(SYS_CLK), .RST_N(RST_N), .CODEC_DEMOTE_SELECT_N(CODEC_DEMOTE_SELECT_N),
   .CODEC_READY(CODEC_READY), .AC97_RESET_N(AC97_RESET_N), .SDATA_IN2_PULLDOWN(SDATA_IN2_PULLDOWN),
   .MB_CODEC_ENABLE(MB_CODEC_ENABLE), .PRIMARY_ON_RISER(PRIMARY_ON_RISER),
   .CODEC_PRESENT(CODEC_PRESENT), .PRIMARY_PRESENT(PRIMARY_PRESENT), .LINK_READY(LINK_READY));
`default_nettype wire
